// [mssr_regs.svh]
// field positions, codes, reset values and timing counts of the status block
// Function
// - apart from status, data comes from data port after its command code.
// - status byte read whenever chip select, port select, read all low.
// - status bits: motor off, breakpoint, error, wrap, index, done, cmd error, busy.
// - motor-off set by reset, reset command, error stop, manual motor-off stop.
// - manual motor-off takes effect at start; otherwise start clears motor-off.
// - breakpoint flag set once position passes programmed breakpoint.
// - error flag set when position error exceeds loaded threshold.
// - interrupt flags other than trajectory-complete set regardless of mask, held until clear-interrupts.
// - wraparound flag set when position leaves number range.
// - armed index pulse stores position and sets index flag.
// - trajectory-complete equals motor-off OR on-target.
// - command error on data read during write command or vice versa.
// - while busy writes ignored, reads give buffer, no command error.
// - signals read gives two bytes, high first; low byte mirrors status bits 7 to 1.
// - host interrupt on unmasked condition, mirrored in bit 15, cleared by clear.
// - acceleration-loaded set on acceleration write, cleared by start.
// - filter-update set by its command, cleared at end of sample interval.
// - direction and velocity mode take loaded values at start.
// - on-target set at profile end, cleared by next start.
// - stop-on-error and eight-bit output flags set and cleared by their commands.
// - signals bit 0 set by index arm, held until next index pulse.
`ifndef MSSR_REGS_SVH
`define MSSR_REGS_SVH
`define MSSR_OP_RESET 8'h00
`define MSSR_OP_START 8'h01
`define MSSR_OP_ARM_INDEX 8'h03
`define MSSR_OP_FILTER_UPDATE 8'h04
`define MSSR_OP_NARROW 8'h05
`define MSSR_OP_WIDE 8'h06
`define MSSR_OP_READ_INDEX 8'h09
`define MSSR_OP_READ_SIGNALS 8'h0C
`define MSSR_OP_ERR_INT_LIMIT 8'h1A
`define MSSR_OP_ERR_STOP_LIMIT 8'h1B
`define MSSR_OP_MASK 8'h1C
`define MSSR_OP_CLEAR_INT 8'h1D
`define MSSR_OP_LOAD_TRAJ 8'h1F
`define MSSR_OP_ABS_BP 8'h20
`define MSSR_OP_REL_BP 8'h21
`define MSSR_TRJ_FWD 12
`define MSSR_TRJ_VEL 11
`define MSSR_TRJ_OFF 8
`define MSSR_TRJ_ACC 5
`define MSSR_RST_MOTOR_OFF 1'b1
`define MSSR_RST_EIGHT_BIT 1'b1
`define MSSR_RST_MASK 6'h00
`define MSSR_RST_THRESH 16'h7FFF
`define MSSR_CLK_NS 100
`define MSSR_BUSY_NS 400
`define MSSR_BUSY_CYC ((`MSSR_BUSY_NS + `MSSR_CLK_NS - 1) / `MSSR_CLK_NS)
`endif

// [mssr_pkg.sv]
// types of the status block
package mssr_pkg;
    typedef enum logic [1:0] {
        MSSR_IDLE = 2'b00,
        MSSR_WRITE = 2'b01,
        MSSR_READ = 2'b11
    } mssr_mode_type;
    typedef struct packed {
        logic cmd_wr;
        logic data_wr;
        logic data_rd;
        logic [7:0] data;
    } mssr_host_ev_type;
    typedef struct packed {
        logic motor_off;
        logic vel_mode;
        logic fwd;
        logic stop_on_err;
        logic eight_bit;
        logic filter_upd;
    } mssr_ctrl_type;
endpackage : mssr_pkg

// [mssr_sticky.sv]
// sticky flags, set wins over clear
`timescale 1ns/1ps
module mssr_sticky #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [W-1:0] set_i,
    input wire logic clr_i,
    output logic [W-1:0] flag_o
);
    wire [W-1:0] next_flag = set_i | (clr_i ? '0 : flag_o);
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            flag_o <= '0;
        end else begin
            flag_o <= next_flag;
        end
    end
endmodule : mssr_sticky

// [mssr_host_port.sv]
// host strobe front end: one pulse per finished strobe
`timescale 1ns/1ps
module mssr_host_port (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic port_select_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_i,
    output logic data_oe_n_o,
    output mssr_pkg::mssr_host_ev_type ev_o
);
    import mssr_pkg::*;
    logic rd_n_q;
    logic wr_n_q;
    logic sel_q;
    logic ps_n_q;
    logic [7:0] wdata;
    // strobe ends on its rising edge
    wire rd_end = ~rd_n_q & rd_n_i & sel_q;
    wire wr_end = ~wr_n_q & wr_n_i & sel_q;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            sel_q <= 1'b0;
            ps_n_q <= 1'b1;
            wdata <= 8'h00;
        end else begin
            rd_n_q <= rd_n_i;
            wr_n_q <= wr_n_i;
            sel_q <= ~cs_n_i;
            ps_n_q <= port_select_n_i;
            if (~wr_n_i & ~cs_n_i) begin
                wdata <= data_i;
            end
        end
    end
    assign ev_o.cmd_wr = wr_end & ~ps_n_q;
    assign ev_o.data_wr = wr_end & ps_n_q;
    assign ev_o.data_rd = rd_end & ps_n_q;
    assign ev_o.data = wdata;
    assign data_oe_n_o = cs_n_i | rd_n_i;
endmodule : mssr_host_port

// [mssr_top.sv]
// status, signals and index reporting with host port decode
`timescale 1ns/1ps
`include "mssr_regs.svh"
module mssr_top #(
    parameter int BUSY_CYC = `MSSR_BUSY_CYC
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic port_select_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_n_o,
    output logic host_irq_o,
    input wire logic [31:0] position_i,
    input wire logic [15:0] pos_error_i,
    input wire logic index_pulse_i,
    input wire logic traj_done_i,
    input wire logic sample_end_i,
    output mssr_pkg::mssr_ctrl_type ctrl_o
);
    import mssr_pkg::*;

    mssr_host_ev_type ev;
    mssr_mode_type mode;
    logic [7:0] cmd;
    logic [2:0] nbyte;
    logic [31:0] wsr;
    logic [31:0] rbuf;
    logic [3:0] busy_cnt;
    logic [15:0] pend;
    logic [15:0] thresh;
    logic [31:0] bp;
    logic bp_arm;
    logic bp_fwd;
    logic [5:0] mask;
    logic [31:0] idx_pos;
    logic idx_arm;
    logic motor_off;
    logic on_target;
    logic acc_loaded;
    logic filter_upd;
    logic vel_mode;
    logic fwd;
    logic stop_err;
    logic eight_bit;
    logic [31:0] pos_q;
    logic [4:0] stk;
    logic [0:0] irq;

    mssr_host_port u_port (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .cs_n_i(cs_n_i),
        .port_select_n_i(port_select_n_i),
        .rd_n_i(rd_n_i),
        .wr_n_i(wr_n_i),
        .data_i(data_i),
        .data_oe_n_o(data_oe_n_o),
        .ev_o(ev)
    );

    // transfers while busy are dropped silently
    wire busy = busy_cnt != 4'h0;
    wire take_cmd = ev.cmd_wr & ~busy;
    wire take_wr = ev.data_wr & ~busy;
    wire take_rd = ev.data_rd & ~busy;
    wire wr_ok = take_wr & (mode == MSSR_WRITE);
    wire rd_ok = take_rd & (mode == MSSR_READ);
    wire bad_io = (take_wr & (mode != MSSR_WRITE)) | (take_rd & (mode != MSSR_READ));

    wire [7:0] op = ev.data;
    wire op_reset = take_cmd & (op == `MSSR_OP_RESET);
    wire op_start = take_cmd & (op == `MSSR_OP_START);
    wire op_arm = take_cmd & (op == `MSSR_OP_ARM_INDEX);
    wire op_filt = take_cmd & (op == `MSSR_OP_FILTER_UPDATE);
    wire op_narrow = take_cmd & (op == `MSSR_OP_NARROW);
    wire op_wide = take_cmd & (op == `MSSR_OP_WIDE);
    wire op_rd_idx = take_cmd & (op == `MSSR_OP_READ_INDEX);
    wire op_rd_sig = take_cmd & (op == `MSSR_OP_READ_SIGNALS);
    wire op_lim_int = take_cmd & (op == `MSSR_OP_ERR_INT_LIMIT);
    wire op_lim_stop = take_cmd & (op == `MSSR_OP_ERR_STOP_LIMIT);
    wire op_clear = take_cmd & (op == `MSSR_OP_CLEAR_INT);
    wire is_wr_op = (op == `MSSR_OP_ERR_INT_LIMIT) | (op == `MSSR_OP_ERR_STOP_LIMIT)
        | (op == `MSSR_OP_MASK) | (op == `MSSR_OP_LOAD_TRAJ)
        | (op == `MSSR_OP_ABS_BP) | (op == `MSSR_OP_REL_BP);
    wire is_rd_op = (op == `MSSR_OP_READ_INDEX) | (op == `MSSR_OP_READ_SIGNALS);
    wire rst_all = srst_i | op_reset;

    // write bytes pair into words, high byte first
    wire [31:0] wnext = {wsr[23:0], ev.data};
    // saturate so long trajectory loads never re-reach the control word slot
    wire [2:0] nnext = (nbyte == 3'd7) ? nbyte : nbyte + 3'd1;
    wire ctrl_done = wr_ok & (cmd == `MSSR_OP_LOAD_TRAJ) & (nbyte == 3'd1);
    wire lim_done = wr_ok & ((cmd == `MSSR_OP_ERR_INT_LIMIT)
        | (cmd == `MSSR_OP_ERR_STOP_LIMIT)) & (nbyte == 3'd1);
    wire mask_done = wr_ok & (cmd == `MSSR_OP_MASK) & (nbyte == 3'd1);
    wire bp_done = wr_ok & ((cmd == `MSSR_OP_ABS_BP) | (cmd == `MSSR_OP_REL_BP))
        & (nbyte == 3'd3);
    wire [31:0] bp_new = (cmd == `MSSR_OP_REL_BP) ? position_i + wnext : wnext;

    // condition detectors
    wire bp_hit = bp_fwd ? ($signed(position_i) >= $signed(bp))
        : ($signed(position_i) <= $signed(bp));
    wire e_bp = bp_arm & bp_hit;
    wire [15:0] err_abs = pos_error_i[15] ? 16'h0000 - pos_error_i : pos_error_i;
    wire e_err = err_abs > thresh;
    // jump between the two ends of the position range
    wire e_wrap = ((pos_q[31:29] == 3'b001) & (position_i[31:29] == 3'b110))
        | ((pos_q[31:29] == 3'b110) & (position_i[31:29] == 3'b001));
    wire e_idx = idx_arm & index_pulse_i;
    wire traj = motor_off | on_target;
    logic traj_q;
    wire e_traj = traj & ~traj_q;

    mssr_sticky #(
        .W(5)
    ) u_flags (
        .clock_i(clock_i),
        .srst_i(rst_all),
        .set_i({e_bp, e_err, e_wrap, e_idx, bad_io}),
        .clr_i(op_clear),
        .flag_o(stk)
    );

    wire [5:0] cond = {e_bp, e_err, e_wrap, e_idx, e_traj, bad_io};
    mssr_sticky #(
        .W(1)
    ) u_irq (
        .clock_i(clock_i),
        .srst_i(rst_all),
        .set_i(|(cond & mask)),
        .clr_i(op_clear),
        .flag_o(irq)
    );

    wire [7:0] status = {motor_off, stk[4], stk[3], stk[2], stk[1], traj, stk[0], busy};
    wire [15:0] signals = {irq[0], acc_loaded, filter_upd, fwd, vel_mode, on_target,
        stop_err, eight_bit, status[7:1], idx_arm};

    // host port sequencing
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            mode <= MSSR_IDLE;
            cmd <= 8'h00;
            nbyte <= 3'd0;
            wsr <= 32'h0000_0000;
        end else if (take_cmd) begin
            cmd <= op;
            nbyte <= 3'd0;
            wsr <= 32'h0000_0000;
            mode <= is_wr_op ? MSSR_WRITE : (is_rd_op ? MSSR_READ : MSSR_IDLE);
        end else if (wr_ok | rd_ok) begin
            nbyte <= nnext;
            wsr <= wnext;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            busy_cnt <= 4'h0;
        end else if (take_cmd | wr_ok | rd_ok) begin
            busy_cnt <= 4'(BUSY_CYC);
        end else if (busy) begin
            busy_cnt <= busy_cnt - 4'h1;
        end
    end

    // read buffer, high byte leaves first
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rbuf <= 32'h0000_0000;
        end else if (op_rd_sig) begin
            rbuf <= {signals, 16'h0000};
        end else if (op_rd_idx) begin
            rbuf <= idx_pos;
        end else if (rd_ok) begin
            rbuf <= {rbuf[23:0], 8'h00};
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            data_o <= 8'h00;
        end else if (~port_select_n_i) begin
            data_o <= status;
        end else begin
            data_o <= rbuf[31:24];
        end
    end

    // loaded parameters
    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            pend <= 16'h0000;
            thresh <= `MSSR_RST_THRESH;
            mask <= `MSSR_RST_MASK;
            bp <= 32'h0000_0000;
            bp_fwd <= 1'b0;
        end else begin
            if (ctrl_done) begin
                pend <= wnext[15:0];
            end
            if (lim_done) begin
                thresh <= wnext[15:0];
            end
            if (mask_done) begin
                mask <= wnext[6:1];
            end
            if (bp_done) begin
                bp <= bp_new;
                bp_fwd <= $signed(bp_new) >= $signed(position_i);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            bp_arm <= 1'b0;
        end else if (bp_done) begin
            bp_arm <= 1'b1;
        end else if (e_bp) begin
            bp_arm <= 1'b0;
        end
    end

    // index capture
    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            idx_arm <= 1'b0;
            idx_pos <= 32'h0000_0000;
        end else begin
            if (e_idx) begin
                idx_pos <= position_i;
            end
            if (op_arm) begin
                idx_arm <= 1'b1;
            end else if (index_pulse_i) begin
                idx_arm <= 1'b0;
            end
        end
    end

    // motion flags
    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            motor_off <= `MSSR_RST_MOTOR_OFF;
        end else if (e_err & stop_err) begin
            motor_off <= 1'b1;
        end else if (op_start) begin
            motor_off <= pend[`MSSR_TRJ_OFF];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            vel_mode <= 1'b0;
            fwd <= 1'b0;
        end else if (op_start) begin
            vel_mode <= pend[`MSSR_TRJ_VEL];
            fwd <= pend[`MSSR_TRJ_FWD];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            on_target <= 1'b0;
        end else if (traj_done_i) begin
            on_target <= 1'b1;
        end else if (op_start) begin
            on_target <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            acc_loaded <= 1'b0;
        end else if (ctrl_done & wnext[`MSSR_TRJ_ACC]) begin
            acc_loaded <= 1'b1;
        end else if (op_start) begin
            acc_loaded <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            filter_upd <= 1'b0;
        end else if (op_filt) begin
            filter_upd <= 1'b1;
        end else if (sample_end_i) begin
            filter_upd <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_all) begin
            stop_err <= 1'b0;
            eight_bit <= `MSSR_RST_EIGHT_BIT;
        end else begin
            if (op_lim_stop) begin
                stop_err <= 1'b1;
            end else if (op_lim_int) begin
                stop_err <= 1'b0;
            end
            if (op_narrow) begin
                eight_bit <= 1'b1;
            end else if (op_wide) begin
                eight_bit <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pos_q <= 32'h0000_0000;
            traj_q <= 1'b0;
        end else begin
            pos_q <= position_i;
            traj_q <= traj;
        end
    end

    assign host_irq_o = irq[0];
    assign ctrl_o.motor_off = motor_off;
    assign ctrl_o.vel_mode = vel_mode;
    assign ctrl_o.fwd = fwd;
    assign ctrl_o.stop_on_err = stop_err;
    assign ctrl_o.eight_bit = eight_bit;
    assign ctrl_o.filter_upd = filter_upd;
endmodule : mssr_top

// [mssr_top_assertions.sv]
// port-level checks for the status block
`timescale 1ns/1ps
module mssr_top_assertions (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic port_select_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe_n_o,
    input wire logic host_irq_o,
    input wire logic sample_end_i,
    input wire mssr_pkg::mssr_ctrl_type ctrl_o
);
    import mssr_pkg::*;
    // cycles since the host last held a write strobe
    logic [3:0] wr_age;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            wr_age <= 4'hF;
        end else if (!cs_n_i && !wr_n_i) begin
            wr_age <= 4'h0;
        end else if (wr_age != 4'hF) begin
            wr_age <= wr_age + 4'h1;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    a_oe_read_drive: assert property (!cs_n_i && !rd_n_i |-> !data_oe_n_o)
        else $error("bus not driven in read");
    a_oe_idle_release: assert property (cs_n_i |-> data_oe_n_o)
        else $error("bus driven while deselected");
    a_status_motor_bit: assert property (!$past(srst_i) && !$past(port_select_n_i)
        && !$past(port_select_n_i, 2) && $stable(ctrl_o.motor_off)
        && $past(ctrl_o.motor_off, 2) == ctrl_o.motor_off |-> data_o[7] == ctrl_o.motor_off)
        else $error("status bit 7 differs from motor off");
    a_reset_values: assert property ($fell(srst_i) |-> !host_irq_o && ctrl_o.motor_off
        && ctrl_o.eight_bit && !ctrl_o.vel_mode && !ctrl_o.stop_on_err && !ctrl_o.filter_upd)
        else $error("wrong values after reset");
    a_irq_clear_cause: assert property ($fell(host_irq_o) |-> wr_age < 4'h8)
        else $error("irq dropped without a command");
    a_mode_by_command: assert property (!$past(srst_i)
        && $changed({ctrl_o.vel_mode, ctrl_o.fwd}) |-> wr_age < 4'h8)
        else $error("mode changed without a command");
    a_limit_by_command: assert property (!$past(srst_i)
        && $changed({ctrl_o.stop_on_err, ctrl_o.eight_bit}) |-> wr_age < 4'h8)
        else $error("output flags changed without a command");
    a_filter_sample_end: assert property (ctrl_o.filter_upd && sample_end_i && wr_age != 4'h0
        |=> !ctrl_o.filter_upd)
        else $error("filter flag outlived its interval");
    a_filter_by_command: assert property ($rose(ctrl_o.filter_upd) |-> wr_age < 4'h8)
        else $error("filter flag rose without a command");
endmodule : mssr_top_assertions
bind mssr_top mssr_top_assertions u_chk (.clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n_i),
    .port_select_n_i(port_select_n_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .host_irq_o(host_irq_o), .sample_end_i(sample_end_i),
    .ctrl_o(ctrl_o));

// [mssr_host_model.sv]
// host processor model on the parallel port
`timescale 1ns/1ps
module mssr_host_model (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    output logic cs_n_o,
    output logic ps_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [7:0] dq_o,
    output logic hang_o
);
    initial begin
        cs_n_o = 1'b1;
        ps_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        dq_o = 8'h00;
        hang_o = 1'b0;
    end
    // one strobe, held until the edge that takes it
    task automatic xfer(input logic ps, input logic wr, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge clock_i);
        cs_n_o <= 1'b0;
        ps_n_o <= ps;
        rd_n_o <= wr;
        wr_n_o <= !wr;
        dq_o <= wr ? d : ~dq_o;
        repeat (2) @(posedge clock_i);
        #1 q = rdata_i;
        @(posedge clock_i);
        rd_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        @(posedge clock_i);
        cs_n_o <= 1'b1;
        dq_o <= ~dq_o;
    endtask : xfer
    task automatic ready();
        logic [7:0] s;
        s = 8'hFF;
        for (int i = 0; i < 32 && s[0] !== 1'b0; i++) begin
            xfer(1'b0, 1'b0, 8'h00, s);
        end
        if (s[0] !== 1'b0) begin
            hang_o = 1'b1;
        end
    endtask : ready
    task automatic cmd(input logic [7:0] op);
        logic [7:0] q;
        ready();
        xfer(1'b0, 1'b1, op, q);
    endtask : cmd
    task automatic put(input logic [7:0] d);
        logic [7:0] q;
        ready();
        xfer(1'b1, 1'b1, d, q);
    endtask : put
    task automatic get(output logic [7:0] q);
        ready();
        xfer(1'b1, 1'b0, 8'h00, q);
    endtask : get
    task automatic w16(input logic [7:0] op, input logic [15:0] w);
        cmd(op);
        put(w[15:8]);
        put(w[7:0]);
    endtask : w16
    task automatic w32(input logic [7:0] op, input logic [31:0] v);
        cmd(op);
        for (int i = 3; i >= 0; i--) begin
            put(v[8*i +: 8]);
        end
    endtask : w32
endmodule : mssr_host_model

// [motion_status_signals_report_tb_top.sv]
// self-checking bench for the status block
`timescale 1ns/1ps
`include "mssr_regs.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t: %h not %h", $time, (a), (e)); end end
module motion_status_signals_report_tb_top;
    import mssr_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic cs_n, ps_n, rd_n, wr_n, oe_n, irq, hang;
    logic [7:0] dq, rdata, q;
    logic [2:0] ev = 3'h0;
    logic [31:0] pos = 32'h0;
    logic [15:0] perr = 16'h0;
    mssr_ctrl_type ctrl;
    int n_fail = 0;
    int n_tests = 0;
    always #50 clock_i = ~clock_i;
    mssr_top #(.BUSY_CYC(8)) DUT (.clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n),
        .port_select_n_i(ps_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(dq), .data_o(rdata),
        .data_oe_n_o(oe_n), .host_irq_o(irq), .position_i(pos), .pos_error_i(perr),
        .index_pulse_i(ev[2]), .traj_done_i(ev[1]), .sample_end_i(ev[0]), .ctrl_o(ctrl));
    mssr_host_model host (.clock_i(clock_i), .rdata_i(rdata), .cs_n_o(cs_n), .ps_n_o(ps_n),
        .rd_n_o(rd_n), .wr_n_o(wr_n), .dq_o(dq), .hang_o(hang));
    task automatic conclude();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    always @(posedge hang) begin
        n_fail++;
        conclude();
    end
    task automatic st(input logic [7:0] e);
        host.ready();
        host.xfer(1'b0, 1'b0, 8'h00, q);
        `CHK(q, e)
    endtask : st
    task automatic cc(input mssr_ctrl_type e);
        host.ready();
        `CHK(ctrl, e)
    endtask : cc
    task automatic sig(input logic [15:0] e);
        host.cmd(`MSSR_OP_READ_SIGNALS);
        host.get(q);
        `CHK(q, e[15:8])
        host.get(q);
        `CHK(q, e[7:0])
    endtask : sig
    task automatic pulse(input int b);
        @(posedge clock_i) ev[b] <= 1'b1;
        @(posedge clock_i) ev[b] <= 1'b0;
    endtask : pulse
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    initial begin
        repeat (20) @(posedge clock_i);
        srst_i <= 1'b0;
        st(8'h84);
        cc(6'b100010);
        sig(16'h0184);
        done("reset");
        host.put(8'h55);
        st(8'h86);
        `CHK(irq, 1'b0)
        host.w16(`MSSR_OP_MASK, 16'h0002);
        host.get(q);
        st(8'h86);
        `CHK(irq, 1'b1)
        sig(16'h8186);
        host.cmd(`MSSR_OP_CLEAR_INT);
        st(8'h84);
        `CHK(irq, 1'b0)
        done("errors");
        host.cmd(`MSSR_OP_READ_SIGNALS);
        host.xfer(1'b1, 1'b1, 8'h55, q);
        st(8'h84);
        done("busy");
        host.w16(`MSSR_OP_LOAD_TRAJ, 16'h1820);
        cc(6'b100010);
        sig(16'h4184);
        host.cmd(`MSSR_OP_START);
        cc(6'b011010);
        sig(16'h1900);
        pulse(1);
        st(8'h04);
        host.w16(`MSSR_OP_LOAD_TRAJ, 16'h0100);
        cc(6'b011010);
        host.cmd(`MSSR_OP_START);
        cc(6'b100010);
        st(8'h84);
        done("trajectory");
        host.w16(`MSSR_OP_LOAD_TRAJ, 16'h0000);
        host.cmd(`MSSR_OP_START);
        host.w16(`MSSR_OP_ERR_STOP_LIMIT, 16'h0010);
        cc(6'b000110);
        @(posedge clock_i) perr <= 16'h0011;
        st(8'hA4);
        @(posedge clock_i) perr <= 16'h0000;
        host.w16(`MSSR_OP_ERR_INT_LIMIT, 16'h7FFF);
        cc(6'b100010);
        host.cmd(`MSSR_OP_WIDE);
        cc(6'b100000);
        host.cmd(`MSSR_OP_NARROW);
        cc(6'b100010);
        host.cmd(`MSSR_OP_FILTER_UPDATE);
        cc(6'b100011);
        pulse(0);
        cc(6'b100010);
        done("modes");
        host.cmd(`MSSR_OP_CLEAR_INT);
        host.cmd(`MSSR_OP_ARM_INDEX);
        sig(16'h0185);
        @(posedge clock_i) pos <= 32'h12345678;
        pulse(2);
        st(8'h8C);
        sig(16'h018C);
        host.cmd(`MSSR_OP_READ_INDEX);
        for (int i = 3; i >= 0; i--) begin
            host.get(q);
            `CHK(q, 8'(32'h12345678 >> (8 * i)))
        end
        done("index");
        host.cmd(`MSSR_OP_CLEAR_INT);
        @(posedge clock_i) pos <= 32'h3FFFFFF0;
        host.w32(`MSSR_OP_ABS_BP, 32'h3FFFFFF8);
        st(8'h84);
        @(posedge clock_i) pos <= 32'h3FFFFFFA;
        st(8'hC4);
        @(posedge clock_i) pos <= 32'hC0000000;
        st(8'hD4);
        done("position");
        host.cmd(`MSSR_OP_CLEAR_INT);
        host.w32(`MSSR_OP_REL_BP, 32'h00000010);
        st(8'h84);
        @(posedge clock_i) pos <= 32'hC0000010;
        st(8'hC4);
        host.w16(`MSSR_OP_LOAD_TRAJ, 16'h0020);
        for (int i = 0; i < 12; i++) begin
            host.put((i == 6) ? 8'h18 : 8'h00);
        end
        host.cmd(`MSSR_OP_START);
        cc(6'b000010);
        host.cmd(`MSSR_OP_WIDE);
        host.cmd(`MSSR_OP_RESET);
        st(8'h84);
        cc(6'b100010);
        `CHK(irq, 1'b0)
        done("reset command");
        conclude();
    end
endmodule : motion_status_signals_report_tb_top
